// ### include/serial_rx_pkg.sv
// Purpose: constants and carrier types of the serial receiver
// Assumes: 32-bit apb, one aligned word per register
// Notes:   register offsets are byte addresses
package serial_rx_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_DATA     = 8'h04;
  localparam logic [7:0]  OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0]  OFS_CTRL_TWO = 8'h0c;
  localparam logic [7:0]  OFS_BAUD     = 8'h10;
  // status bit positions (flag vector order)
  localparam int          ST_FULL      = 5;
  localparam int          ST_IDLE      = 4;
  localparam int          ST_OVERRUN   = 3;
  localparam int          ST_NOISE     = 2;
  localparam int          ST_FRAMING   = 1;
  localparam int          ST_PARITY    = 0;
  // serial_control_one fields
  localparam int          C1_NINTH     = 7;
  localparam int          C1_WORD_LEN  = 4;
  localparam int          C1_WAKE      = 3;
  localparam int          C1_PAR_EN    = 2;
  localparam int          C1_PAR_ODD   = 1;
  localparam int          C1_PAR_IE    = 0;
  // serial_control_two fields
  localparam int          C2_RX_IE     = 5;
  localparam int          C2_IDLE_IE   = 4;
  localparam int          C2_RX_EN     = 2;
  localparam int          C2_MUTE      = 1;
  // baud_select_reg fields
  localparam int          BD_PRE_LSB   = 6;
  localparam int          BD_TX_LSB    = 3;
  localparam int          BD_RX_LSB    = 0;
  // sampling figures
  localparam logic [4:0]  SMP_PER_BIT  = 5'd16;
  localparam logic [4:0]  SMP_EDGE_A   = 5'd3;
  localparam logic [4:0]  SMP_EDGE_B   = 5'd5;
  localparam logic [4:0]  SMP_EDGE_C   = 5'd7;
  localparam logic [4:0]  SMP_MAJ_A    = 5'd8;
  localparam logic [4:0]  SMP_MAJ_B    = 5'd9;
  localparam logic [4:0]  SMP_MAJ_C    = 5'd10;
  localparam logic [3:0]  PRE_1        = 4'd1;
  localparam logic [3:0]  PRE_3        = 4'd3;
  localparam logic [3:0]  PRE_4        = 4'd4;
  localparam logic [3:0]  PRE_13       = 4'd13;
  localparam logic [3:0]  BITS_SHORT   = 4'd8;
  localparam logic [3:0]  BITS_LONG    = 4'd9;
  localparam logic [5:0]  FLAGS_CLEAR  = 6'h00;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_phase_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage : serial_rx_pkg

// ### verilog/async_serial_receiver.sv
// Purpose: receive half of an async nrz serial port with apb registers
// Assumes: serial_in_pin is synchronous to clk_in
// Notes:   transmit datapath is absent; only its baud tick is produced
// Contract
// - 8 or 9 bit words; ninth bit lands in control one
// - bits shift in lsb first into a separate shift register
// - receiver enable starts the hunt for a start bit
// - completed word goes to holding buffer, sets full, may interrupt
// - status read then data read clears full/overrun/noise/framing
// - break is handled exactly as a framing error
// - idle frame sets only the idle flag, may interrupt
// - overrun keeps buffer, drops shifted word, may interrupt
// - data bit noisy unless samples 8, 9, 10 agree
// - start noise combines edge validity and samples 8 to 10
// - noise rises with full, data still moves, no own interrupt
// - false start discards frame, noise held for next frame
// - framing on missing stop or break, rises with full
// - tx and rx rates: clock over 16 times prescale times divider
// - two-bit prescale select gives 1, 3, 4 or 13
// - three-bit tx and rx selects give powers of two to 128
// - mute sets no status flags and inhibits receive interrupts
// - idle wake clears mute without setting idle flag
// - address mark wake clears mute and receives the word
// - parity frames carry 7 or 8 data bits plus parity
// - sixteen samples per bit, majority of 8, 9, 10, resync on start
// - valid edge needs three ones before, no one at 3, 5, 7
// - parity even or odd check sets parity flag, may interrupt
// - address mark uses the top data bit, never parity
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module async_serial_receiver (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire serial_rx_pkg::apb_req_t apb_req_in,
  output serial_rx_pkg::apb_rsp_t      apb_rsp_out,
  input  wire logic                    serial_in_pin,
  input  wire logic                    global_irq_mask_in,
  output logic                         irq_request_out,
  output logic                         tx_baud_tick_out,
  output logic                         rx_sample_tick_out
);
  import serial_rx_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] baud;
    logic [5:0] flags;
    logic [5:0] seen;
    logic [8:0] holding;
    logic [3:0] pre_cnt;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic       tx_tick;
    logic       rx_tick;
    rx_phase_t  phase;
    logic [4:0] smp;
    logic [3:0] bitn;
    logic [2:0] hist;
    logic [2:0] maj3;
    logic       edge_ok;
    logic       frame_noise;
    logic       noise_pend;
    logic       frame_fail;
    logic [8:0] shift;
    logic [7:0] idle_cnt;
    logic       idle_arm;
    logic [31:0] prdata;
    logic       pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  // common prescale value from its two-bit select
  function automatic logic [3:0] prescale_of(input logic [1:0] sel);
    case (sel)
      2'd0:    prescale_of = PRE_1;
      2'd1:    prescale_of = PRE_3;
      2'd2:    prescale_of = PRE_4;
      default: prescale_of = PRE_13;
    endcase
  endfunction : prescale_of

  // power of two divider, kept one below for a terminal count
  function automatic logic [7:0] div_last(input logic [2:0] sel);
    div_last = 8'((9'd1 << sel) - 9'd1);
  endfunction : div_last

  // majority of the three centre samples
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  // samples in one whole frame of the current format
  function automatic logic [7:0] frame_samples(input logic [3:0] n);
    frame_samples = 8'({4'd0, n} + 8'd2) << 4;
  endfunction : frame_samples

  logic       word_len;
  logic       wake_method;
  logic       parity_enable;
  logic       parity_odd_select;
  logic       mute_request;
  logic       receiver_enable_bit;
  logic [3:0] nbits;
  logic [3:0] top_bit;
  logic [3:0] addr_bit;
  logic       sample;
  logic       access;
  logic       rd_status;
  logic       rd_data;

  assign word_len            = s_q.ctrl_one[C1_WORD_LEN];
  assign wake_method         = s_q.ctrl_one[C1_WAKE];
  assign parity_enable       = s_q.ctrl_one[C1_PAR_EN];
  assign parity_odd_select   = s_q.ctrl_one[C1_PAR_ODD];
  assign mute_request        = s_q.ctrl_two[C2_MUTE];
  assign receiver_enable_bit = s_q.ctrl_two[C2_RX_EN];
  assign nbits    = word_len ? BITS_LONG : BITS_SHORT;
  assign top_bit  = nbits - 4'd1;
  // the address mark is the top data bit, parity stands above it
  assign addr_bit = parity_enable ? nbits - 4'd2 : top_bit;
  assign sample   = serial_in_pin;
  assign access   = apb_req_in.psel & apb_req_in.penable;
  assign rd_status = access & ~apb_req_in.pwrite &
                     (apb_req_in.paddr == OFS_STATUS);
  assign rd_data   = access & ~apb_req_in.pwrite &
                     (apb_req_in.paddr == OFS_DATA);

  always_comb begin
    logic [8:0] word;
    logic       frame_done;
    logic       idle_event;
    logic       par_bad;
    logic       noisy;
    logic       pre_wrap;
    word       = s_q.shift;
    frame_done = 1'b0;
    idle_event = 1'b0;
    par_bad    = 1'b0;
    noisy      = 1'b0;
    pre_wrap   = 1'b0;
    s_d        = s_q;
    s_d.tx_tick = 1'b0;
    s_d.rx_tick = 1'b0;

    // shared prescaler feeding independent tx and rx dividers
    if (s_q.pre_cnt >= prescale_of(s_q.baud[BD_PRE_LSB +: 2]) - 4'd1) begin
      s_d.pre_cnt = '0;
      pre_wrap    = 1'b1;
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 4'd1;
    end
    if (pre_wrap) begin
      if (s_q.tx_cnt >= div_last(s_q.baud[BD_TX_LSB +: 3])) begin
        s_d.tx_cnt  = '0;
        s_d.tx_tick = 1'b1;
      end else begin
        s_d.tx_cnt = s_q.tx_cnt + 8'd1;
      end
      if (s_q.rx_cnt >= div_last(s_q.baud[BD_RX_LSB +: 3])) begin
        s_d.rx_cnt  = '0;
        s_d.rx_tick = 1'b1;
      end else begin
        s_d.rx_cnt = s_q.rx_cnt + 8'd1;
      end
    end

    // receiver sequencer, one step per sixteenth of a bit
    if (!receiver_enable_bit) begin
      s_d.phase    = RX_HUNT;
      s_d.hist     = '0;
      s_d.idle_cnt = '0;
      s_d.idle_arm = 1'b1;
    end else if (s_q.rx_tick) begin
      // history runs in every phase so a start straight after a
      // dropped frame still sees the ones that really preceded it
      s_d.hist = {s_q.hist[1:0], sample};
      case (s_q.phase)
        RX_HUNT: begin
          if (!sample) begin
            // falling edge: restart the sample clock here
            s_d.phase       = RX_START;
            s_d.smp         = 5'd1;
            s_d.edge_ok     = &s_q.hist;
            s_d.maj3        = '0;
            s_d.frame_noise = 1'b0;
            s_d.idle_cnt    = '0;
            s_d.idle_arm    = 1'b1;
          end else if (s_q.idle_arm) begin
            if (s_q.idle_cnt >= frame_samples(nbits) - 8'd1) begin
              idle_event   = 1'b1;
              s_d.idle_arm = 1'b0;
              s_d.idle_cnt = '0;
            end else begin
              s_d.idle_cnt = s_q.idle_cnt + 8'd1;
            end
          end
        end
        RX_START: begin
          s_d.smp = s_q.smp + 5'd1;
          if ((s_q.smp == SMP_EDGE_A || s_q.smp == SMP_EDGE_B ||
               s_q.smp == SMP_EDGE_C) && sample) begin
            s_d.edge_ok = 1'b0;
          end
          if (s_q.smp >= SMP_MAJ_A && s_q.smp <= SMP_MAJ_C) begin
            s_d.maj3 = {s_q.maj3[1:0], sample};
          end
          if (s_q.smp == SMP_MAJ_C) begin
            if (majority(s_d.maj3)) begin
              // false start: frame dropped, noise kept for later
              s_d.phase = RX_HUNT;
              if (s_d.maj3 != 3'b111) begin
                s_d.noise_pend = 1'b1;
              end
            end else if (s_d.maj3 != 3'b000 || !s_d.edge_ok) begin
              s_d.frame_noise = 1'b1;
            end
          end
          if (s_q.smp == SMP_PER_BIT) begin
            s_d.phase = RX_DATA;
            s_d.smp   = 5'd1;
            s_d.bitn  = '0;
            s_d.shift = '0;
          end
        end
        RX_DATA: begin
          s_d.smp = s_q.smp + 5'd1;
          if (s_q.smp >= SMP_MAJ_A && s_q.smp <= SMP_MAJ_C) begin
            s_d.maj3 = {s_q.maj3[1:0], sample};
          end
          if (s_q.smp == SMP_MAJ_C) begin
            s_d.shift[s_q.bitn] = majority(s_d.maj3);
            if (s_d.maj3 != 3'b000 && s_d.maj3 != 3'b111) begin
              s_d.frame_noise = 1'b1;
            end
          end
          if (s_q.smp == SMP_PER_BIT) begin
            s_d.smp  = 5'd1;
            s_d.bitn = s_q.bitn + 4'd1;
            if (s_q.bitn == top_bit) begin
              s_d.phase = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          s_d.smp = s_q.smp + 5'd1;
          if (s_q.smp >= SMP_MAJ_A && s_q.smp <= SMP_MAJ_C) begin
            s_d.maj3 = {s_q.maj3[1:0], sample};
          end
          if (s_q.smp == SMP_MAJ_C) begin
            // a low stop bit, as in a break, is a framing fault
            s_d.frame_fail = ~majority(s_d.maj3);
            if (s_d.maj3 != 3'b000 && s_d.maj3 != 3'b111) begin
              s_d.frame_noise = 1'b1;
            end
            frame_done = 1'b1;
            s_d.phase  = RX_HUNT;
          end
        end
        default: begin
          s_d.phase = RX_HUNT;
        end
      endcase
    end

    // apb read data and error captured in the setup cycle
    if (apb_req_in.psel && !apb_req_in.penable) begin
      s_d.pslverr = 1'b0;
      s_d.prdata  = READ_ZERO;
      case (apb_req_in.paddr)
        OFS_STATUS:   s_d.prdata[5:0] = s_q.flags;
        OFS_DATA:     s_d.prdata[7:0] = s_q.holding[7:0];
        OFS_CTRL_ONE: begin
          s_d.prdata[7:0]      = s_q.ctrl_one;
          s_d.prdata[C1_NINTH] = s_q.holding[8];
        end
        OFS_CTRL_TWO: s_d.prdata[7:0] = s_q.ctrl_two;
        OFS_BAUD:     s_d.prdata[7:0] = s_q.baud;
        default:      s_d.pslverr = 1'b1;
      endcase
    end

    // writes; the ninth-bit field of control one is read only
    if (access && apb_req_in.pwrite) begin
      case (apb_req_in.paddr)
        OFS_CTRL_ONE: begin
          s_d.ctrl_one = apb_req_in.pwdata[7:0];
          s_d.ctrl_one[C1_NINTH] = 1'b0;
        end
        OFS_CTRL_TWO: s_d.ctrl_two = apb_req_in.pwdata[7:0];
        OFS_BAUD:     s_d.baud = apb_req_in.pwdata[7:0];
        default: begin
        end
      endcase
    end

    // two-step clear: only flags seen by the status read are dropped
    if (rd_status) begin
      s_d.seen = s_q.flags;
    end else if (rd_data) begin
      s_d.flags = s_q.flags & ~s_q.seen;
      s_d.seen  = FLAGS_CLEAR;
    end

    // flag setting comes last so a new event beats a same-cycle clear
    if (idle_event) begin
      if (mute_request) begin
        if (!wake_method) begin
          s_d.ctrl_two[C2_MUTE] = 1'b0;
        end
      end else begin
        s_d.flags[ST_IDLE] = 1'b1;
      end
    end
    if (frame_done) begin
      par_bad = parity_enable &
                ((^(word & ~(9'h1ff << nbits))) ^ parity_odd_select);
      noisy   = s_d.frame_noise | s_q.noise_pend;
      if (mute_request && wake_method && word[addr_bit]) begin
        s_d.ctrl_two[C2_MUTE] = 1'b0;
      end
      if (!mute_request || (wake_method && word[addr_bit])) begin
        if (s_q.flags[ST_FULL] && !(rd_data && s_q.seen[ST_FULL])) begin
          s_d.flags[ST_OVERRUN] = 1'b1;
        end else begin
          s_d.holding = word_len ? word : {1'b0, word[7:0]};
          s_d.flags[ST_FULL] = 1'b1;
          s_d.flags[ST_NOISE]   = s_d.flags[ST_NOISE] | noisy;
          s_d.flags[ST_FRAMING] = s_d.flags[ST_FRAMING] |
                                  s_d.frame_fail;
          s_d.flags[ST_PARITY]  = s_d.flags[ST_PARITY] | par_bad;
          s_d.noise_pend = 1'b0;
        end
      end
    end
  end

  // single state register; reset leaves the receiver off
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q       <= '0;
      s_q.phase <= RX_HUNT;
    end else begin
      s_q <= s_d;
    end
  end

  // interrupt request; mute inhibits every receive source
  always_comb begin
    irq_request_out = ~global_irq_mask_in & ~mute_request & (
      (s_q.ctrl_two[C2_RX_IE] &
       (s_q.flags[ST_FULL] | s_q.flags[ST_OVERRUN])) |
      (s_q.ctrl_two[C2_IDLE_IE] & s_q.flags[ST_IDLE]) |
      (s_q.ctrl_one[C1_PAR_IE] & s_q.flags[ST_PARITY]));
  end

  // zero-wait apb: access phase always completes at once
  assign apb_rsp_out.pready  = access;
  assign apb_rsp_out.pslverr = s_q.pslverr & access;
  assign apb_rsp_out.prdata  = s_q.prdata;
  assign tx_baud_tick_out    = s_q.tx_tick;
  assign rx_sample_tick_out  = s_q.rx_tick;
endmodule : async_serial_receiver
`default_nettype wire

// ### sim/serial_rx_asserts.sv
// Purpose: port level checks of the serial receiver
// Assumes: bench uses the frame set of the top bench
// Notes:   bound onto every receiver instance
`timescale 1ns/1ns
`default_nettype none
module serial_rx_checker (
  input wire logic                    clk_in,
  input wire logic                    reset_in,
  input wire serial_rx_pkg::apb_req_t apb_req_in,
  input wire serial_rx_pkg::apb_rsp_t apb_rsp_out,
  input wire logic                    serial_in_pin,
  input wire logic                    global_irq_mask_in,
  input wire logic                    irq_request_out,
  input wire logic                    tx_baud_tick_out,
  input wire logic                    rx_sample_tick_out
);
  import serial_rx_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic acc;
  logic rd;
  logic bad;
  // access phase decode shared by the bus checks
  assign acc = apb_req_in.psel & apb_req_in.penable;
  assign rd  = acc & ~apb_req_in.pwrite;
  assign bad = apb_req_in.paddr > OFS_BAUD;
  // clearing takes two steps: status read with full seen, then data read
  sequence st_full_s;
    rd && apb_req_in.paddr == OFS_STATUS && apb_rsp_out.prdata[ST_FULL];
  endsequence
  sequence dt_read_s;
    rd && apb_req_in.paddr == OFS_DATA;
  endsequence
  ready_follows_a : assert property (apb_rsp_out.pready == acc)
    else $error("pready differs from select and enable");
  err_unmapped_a : assert property (acc && bad |-> apb_rsp_out.pslverr)
    else $error("no error on unmapped address");
  err_mapped_a : assert property
    (acc && !bad && apb_req_in.paddr[1:0] == 2'b00 |-> !apb_rsp_out.pslverr)
    else $error("error on mapped address");
  rd_upper_a : assert property (rd |-> apb_rsp_out.prdata[31:8] == 24'h0)
    else $error("read bits above seven not zero");
  rd_unmapped_a : assert property (rd && bad |-> apb_rsp_out.prdata == 0)
    else $error("unmapped read not zero");
  irq_masked_a : assert property (
    global_irq_mask_in |-> !irq_request_out)
    else $error("interrupt while masked");
  reset_quiet_a : assert property (
    $fell(reset_in) |-> !irq_request_out && !tx_baud_tick_out
      && !rx_sample_tick_out)
    else $error("outputs active after reset");
  clear_seq_a : assert property (
    st_full_s ##[2:6] dt_read_s |=> !irq_request_out)
    else $error("interrupt kept after clearing reads");
endmodule : serial_rx_checker
bind async_serial_receiver serial_rx_checker u_chk (
  .clk_in             (clk_in),
  .reset_in           (reset_in),
  .apb_req_in         (apb_req_in),
  .apb_rsp_out        (apb_rsp_out),
  .serial_in_pin      (serial_in_pin),
  .global_irq_mask_in (global_irq_mask_in),
  .irq_request_out    (irq_request_out),
  .tx_baud_tick_out   (tx_baud_tick_out),
  .rx_sample_tick_out (rx_sample_tick_out)
);
`default_nettype wire

// ### sim/serial_line_model.sv
// Purpose: far end that sends nrz frames into the receiver
// Assumes: paced by the receiver sample tick, sixteen ticks a bit
// Notes:   nb zero sends a short start only; nz 99 means clean
`timescale 1ns/1ns
`default_nettype none
module serial_line_model (
  input  wire logic clk_in,
  input  wire logic tick_in,
  output var logic  line_out
);
  // line rests at mark level between frames
  initial line_out = 1'b1;
  task automatic send(input logic [8:0] w, input int nb, input logic sv,
                      input int nz);
    logic [10:0] f;
    logic        v;
    f = 11'h0;
    for (int i = 0; i < nb; i++)
      f[i+1] = w[i];
    f[nb+1] = sv;
    for (int b = 0; b <= nb + 1; b++) begin
      for (int k = 1; k <= 16; k++) begin
        v = f[b];
        if (nb == 0 && b == 0 && k > 9) // centre votes 0, 1, 1
          v = 1'b1;
        if (b == nz + 1 && k == 9)
          v = ~v;
        line_out <= v;
        @(posedge clk_in);
        while (tick_in !== 1'b1)
          @(posedge clk_in);
      end
    end
    line_out <= 1'b1;
  endtask : send
endmodule : serial_line_model
`default_nettype wire

// ### sim/async_serial_receiver_tb_top.sv
// Purpose: self checking bench of the serial receiver
// Assumes: 25 mhz clock, zero wait state apb
// Notes:   baud zero gives one sample tick per clock in frames
`timescale 1ns/1ns
`default_nettype none
module async_serial_receiver_tb_top;
  import serial_rx_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        mask;
  logic        ser;
  logic        irq;
  logic        txt;
  logic        rxt;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          pre_tab [4] = '{1, 3, 4, 13};

  async_serial_receiver u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .serial_in_pin(ser),
    .global_irq_mask_in(mask), .irq_request_out(irq),
    .tx_baud_tick_out(txt), .rx_sample_tick_out(rxt));
  serial_line_model u_far (.clk_in(clk_in), .tick_in(rxt), .line_out(ser));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // watchdog: a lost handshake must not hang the run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task wrap_up;
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one transfer, request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do
      @(posedge clk_in);
    while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, {24'h0, e});
  endtask : rd

  // cycles between two pulses of the tx (t=1) or rx tick
  task period(input logic t, input int e);
    int n;
    n = 0;
    @(posedge clk_in);
    while ((t ? txt : rxt) !== 1'b1)
      @(posedge clk_in);
    do begin
      @(posedge clk_in);
      n++;
    end while ((t ? txt : rxt) !== 1'b1);
    chk(32'(n), 32'(e));
  endtask : period

  task fr(input logic [8:0] w, input int nb, input logic sv, input int nz,
          input logic [7:0] st);
    u_far.send(w, nb, sv, nz);
    rd(OFS_STATUS, st);
  endtask : fr

  initial begin
    reset_in = 1'b1;
    mask = 1'b0;
    req = '0;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(OFS_STATUS, 8'h00);
    rd(OFS_CTRL_ONE, 8'h00);
    rd(OFS_CTRL_TWO, 8'h00);
    rd(OFS_BAUD, 8'h00);
    rd(8'h40, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    // baud changes only while the receiver is off
    for (int p = 0; p < 4; p++) begin
      wr(OFS_BAUD, {p[1:0], 3'd2, 3'd1});
      period(1'b0, pre_tab[p] * 2);
      period(1'b1, pre_tab[p] * 4);
    end
    wr(OFS_BAUD, 8'h3f);
    period(1'b0, 128);
    period(1'b1, 128);
    wr(OFS_BAUD, 8'h00);
    wr(OFS_CTRL_TWO, 8'h34);
    repeat (220) @(posedge clk_in);
    rd(OFS_STATUS, 8'h10);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    wr(OFS_CTRL_TWO, 8'h24);
    // masked word must not interrupt until unmasked
    mask <= 1'b1;
    u_far.send(9'h0a5, 8, 1'b1, 99);
    chk({31'h0, irq}, 32'h0);
    mask <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_STATUS, 8'h20);
    rd(OFS_DATA, 8'ha5);
    rd(OFS_STATUS, 8'h00);
    // back to back words overrun the unread buffer
    u_far.send(9'h03c, 8, 1'b1, 99);
    fr(9'h0c3, 8, 1'b1, 99, 8'h28);
    rd(OFS_DATA, 8'h3c);
    rd(OFS_STATUS, 8'h00);
    fr(9'h05a, 8, 1'b1, 3, 8'h24);
    rd(OFS_DATA, 8'h5a);
    fr(9'h081, 8, 1'b0, 99, 8'h22);
    rd(OFS_DATA, 8'h81);
    fr(9'h000, 8, 1'b0, 99, 8'h22);
    rd(OFS_DATA, 8'h00);
    u_far.send(9'h000, 0, 1'b1, 99);
    fr(9'h066, 8, 1'b1, 99, 8'h24);
    rd(OFS_DATA, 8'h66);
    wr(OFS_CTRL_ONE, 8'h10);
    fr(9'h1c3, 9, 1'b1, 99, 8'h20);
    rd(OFS_DATA, 8'hc3);
    rd(OFS_CTRL_ONE, 8'h90);
    // receive interrupt off: only the parity interrupt enable may raise irq
    wr(OFS_CTRL_TWO, 8'h04);
    wr(OFS_CTRL_ONE, 8'h05);
    fr(9'h0b5, 8, 1'b1, 99, 8'h21);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    wr(OFS_CTRL_ONE, 8'h06);
    fr(9'h0b5, 8, 1'b1, 99, 8'h20);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    // muted until a word with its top bit set
    wr(OFS_CTRL_ONE, 8'h08);
    wr(OFS_CTRL_TWO, 8'h26);
    fr(9'h012, 8, 1'b1, 99, 8'h00);
    chk({31'h0, irq}, 32'h0);
    fr(9'h092, 8, 1'b1, 99, 8'h20);
    rd(OFS_DATA, 8'h92);
    rd(OFS_CTRL_TWO, 8'h24);
    // muted until the line idles
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CTRL_TWO, 8'h36);
    repeat (240) @(posedge clk_in);
    rd(OFS_CTRL_TWO, 8'h34);
    rd(OFS_STATUS, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wrap_up();
  end
endmodule : async_serial_receiver_tb_top
`default_nettype wire
